// file: rtl/asr_status_regs.sv
// Contract
// (R1) channel_state bits 0-7 read 1 when the channel is enabled, else 0.
// (R2) Conversion-done bit reads 1 only if channel enabled and conversion completed.
// (R3) Channel overrun bit sets on overrun, clears on conversion_status read.
// (R4) Result-available flag sets on a new result, clears on last_result read.
// (R5) Global overrun flag sets on event, clears on conversion_status read.
// (R6) Rx-count-zero flag sets when counter hits zero, clears on counter writes.
// (R7) Both-counts-zero flag is 1 exactly when both rx counters are zero.
// (R8) last_result captures every conversion result and holds it until the next.
// (R9) Writing 1 to irq_enable_set enables that source; 0 has no effect.
// (R10) Writing 1 to irq_enable_clear disables that source; 0 has no effect.
// (R11) irq_mask_view reads 1 for each enabled source, 0 otherwise.
// (R12) Enable, disable and mask share the conversion_status bit layout.
// (R13) Status bits 20-31 and unused upper last_result bits read zero.
// (R14) Interrupt output high while any enabled status flag is set.
// (R15) Conversion-done flag clears when that channel's data register is read.
module asr_status_regs (
  input wire logic refClk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [asr_pkg::NUM_CHANNELS-1:0] channelOnBits,
  input wire asr_pkg::asr_core_evt_t coreEvt,
  input wire logic [asr_pkg::NUM_CHANNELS-1:0] channelDataRead,
  output logic [asr_pkg::NUM_CHANNELS-1:0] channelDataLoad,
  output logic [asr_pkg::COUNT_WIDTH-1:0] rxTransferCounter,
  output logic [asr_pkg::COUNT_WIDTH-1:0] rxNextTransferCounter,
  output logic irqOut
);

  // ==========================================================
  // State
  logic [asr_pkg::NUM_CHANNELS-1:0] convDoneFlag_r, convDoneFlag_nxt;
  logic [asr_pkg::NUM_CHANNELS-1:0] channelOverrunFlag_r, channelOverrunFlag_nxt;
  logic resultAvailableFlag_r, resultAvailableFlag_nxt;
  logic globalOverrunFlag_r, globalOverrunFlag_nxt;
  logic rxCountZeroFlag_r, rxCountZeroFlag_nxt;
  logic [asr_pkg::RESULT_WIDTH-1:0] lastResultValue_r, lastResultValue_nxt;
  logic [asr_pkg::FLAG_WIDTH-1:0] irqEnable_r, irqEnable_nxt;
  logic [asr_pkg::COUNT_WIDTH-1:0] rxCount_r, rxCount_nxt;
  logic [asr_pkg::COUNT_WIDTH-1:0] rxNextCount_r, rxNextCount_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic pready_r, pready_nxt;

  logic access;
  logic xfer;
  logic rdCapture;
  logic wrAccess;
  logic rdAccess;
  logic statusRead;
  logic lastRead;
  logic rxBothCountsZeroFlag;
  logic addrValid;
  logic [asr_pkg::FLAG_WIDTH-1:0] statusWord;

  // ==========================================================
  // Bus decode
  // One wait state: read data and pslverr are registered in the first access cycle
  // and stand while pready is high, so the master takes them at its completing edge.
  // Read side effects happen at capture, so an event after it is never lost.
  assign access = psel && penable;
  assign rdCapture = access && !pready_r && !pwrite;
  assign xfer = access && pready_r;
  assign wrAccess = xfer && pwrite;
  assign rdAccess = rdCapture;
  assign statusRead = rdAccess && (paddr == asr_pkg::ADDR_CONVERSION_STATUS);
  assign lastRead = rdAccess && (paddr == asr_pkg::ADDR_LAST_RESULT);
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always_comb begin
    case (paddr)
      asr_pkg::ADDR_CHANNEL_STATE,
      asr_pkg::ADDR_CONVERSION_STATUS,
      asr_pkg::ADDR_LAST_RESULT,
      asr_pkg::ADDR_IRQ_MASK_VIEW: addrValid = !pwrite;
      asr_pkg::ADDR_IRQ_ENABLE_SET,
      asr_pkg::ADDR_IRQ_ENABLE_CLEAR: addrValid = pwrite;
      asr_pkg::ADDR_RX_TRANSFER_COUNTER,
      asr_pkg::ADDR_RX_NEXT_TRANSFER_COUNTER: addrValid = 1'b1;
      default: addrValid = 1'b0;
    endcase
  end

  // ==========================================================
  // Status word
  assign rxBothCountsZeroFlag = (rxCount_r == asr_pkg::RESET_COUNT) &&
                                (rxNextCount_r == asr_pkg::RESET_COUNT); // see (R7)

  always_comb begin
    statusWord = asr_pkg::RESET_FLAGS; // see (R12)
    // Gated by live enable: a disabled channel never reads done
    statusWord[asr_pkg::POS_CONV_DONE +: asr_pkg::NUM_CHANNELS] =
      convDoneFlag_r & channelOnBits; // see (R2)
    statusWord[asr_pkg::POS_CHANNEL_OVERRUN +: asr_pkg::NUM_CHANNELS] = channelOverrunFlag_r;
    statusWord[asr_pkg::POS_RESULT_AVAILABLE] = resultAvailableFlag_r;
    statusWord[asr_pkg::POS_GLOBAL_OVERRUN] = globalOverrunFlag_r;
    statusWord[asr_pkg::POS_RX_COUNT_ZERO] = rxCountZeroFlag_r;
    statusWord[asr_pkg::POS_RX_BOTH_COUNTS_ZERO] = rxBothCountsZeroFlag;
  end

  assign irqOut = |(statusWord & irqEnable_r); // see (R14)

  // ==========================================================
  // Per-channel flags
  genvar ch;
  generate
    for (ch = 0; ch < asr_pkg::NUM_CHANNELS; ch++) begin : gChan
      logic doneEvt;
      assign doneEvt = coreEvt.convDone && (coreEvt.convChannel == 3'(ch)) &&
                       channelOnBits[ch];
      assign channelDataLoad[ch] = doneEvt;
      // Set wins over a clear in the same cycle
      always_comb begin
        convDoneFlag_nxt[ch] = convDoneFlag_r[ch];
        if (channelDataRead[ch]) begin
          convDoneFlag_nxt[ch] = 1'b0; // see (R15)
        end
        if (!channelOnBits[ch]) begin
          convDoneFlag_nxt[ch] = 1'b0; // see (R2)
        end
        if (doneEvt) begin
          convDoneFlag_nxt[ch] = 1'b1; // see (R2)
        end
        channelOverrunFlag_nxt[ch] = channelOverrunFlag_r[ch];
        if (statusRead) begin
          channelOverrunFlag_nxt[ch] = 1'b0; // see (R3)
        end
        if (coreEvt.channelOverrun[ch]) begin
          channelOverrunFlag_nxt[ch] = 1'b1; // see (R3)
        end
      end
    end
  endgenerate

  // ==========================================================
  // Global flags, result, counters, enables
  always_comb begin
    resultAvailableFlag_nxt = resultAvailableFlag_r;
    globalOverrunFlag_nxt = globalOverrunFlag_r;
    rxCountZeroFlag_nxt = rxCountZeroFlag_r;
    lastResultValue_nxt = lastResultValue_r;
    irqEnable_nxt = irqEnable_r;
    rxCount_nxt = rxCount_r;
    rxNextCount_nxt = rxNextCount_r;

    if (lastRead) begin
      resultAvailableFlag_nxt = 1'b0; // see (R4)
    end
    if (coreEvt.convDone) begin
      resultAvailableFlag_nxt = 1'b1; // see (R4)
      lastResultValue_nxt = coreEvt.convResult; // see (R8)
    end

    if (statusRead) begin
      globalOverrunFlag_nxt = 1'b0; // see (R5)
    end
    if (coreEvt.globalOverrun) begin
      globalOverrunFlag_nxt = 1'b1; // see (R5)
    end

    // Transfer counter: reload of next counter when the current one empties
    if (coreEvt.rxTransferDone && rxCount_r != asr_pkg::RESET_COUNT) begin
      rxCount_nxt = rxCount_r - 16'h0001;
      if (rxCount_r == 16'h0001) begin
        rxCount_nxt = rxNextCount_r;
        rxNextCount_nxt = asr_pkg::RESET_COUNT;
        rxCountZeroFlag_nxt = 1'b1; // see (R6)
      end
    end
    if (wrAccess && paddr == asr_pkg::ADDR_RX_TRANSFER_COUNTER) begin
      rxCount_nxt = pwdata[asr_pkg::COUNT_WIDTH-1:0];
      rxCountZeroFlag_nxt = 1'b0; // see (R6)
    end
    if (wrAccess && paddr == asr_pkg::ADDR_RX_NEXT_TRANSFER_COUNTER) begin
      rxNextCount_nxt = pwdata[asr_pkg::COUNT_WIDTH-1:0];
      rxCountZeroFlag_nxt = 1'b0; // see (R6)
    end

    if (wrAccess && paddr == asr_pkg::ADDR_IRQ_ENABLE_SET) begin
      irqEnable_nxt = irqEnable_r | pwdata[asr_pkg::FLAG_WIDTH-1:0]; // see (R9) (R12)
    end
    if (wrAccess && paddr == asr_pkg::ADDR_IRQ_ENABLE_CLEAR) begin
      irqEnable_nxt = irqEnable_r & ~pwdata[asr_pkg::FLAG_WIDTH-1:0]; // see (R10) (R12)
    end
  end

  // ==========================================================
  // Read data, registered at the access edge
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = access && !pready_r;
    if (access && !pready_r) begin
      pslverr_nxt = !addrValid;
    end
    if (rdAccess) begin
      prdata_nxt = 32'h00000000; // see (R13)
      case (paddr)
        asr_pkg::ADDR_CHANNEL_STATE: begin
          prdata_nxt[asr_pkg::NUM_CHANNELS-1:0] = channelOnBits; // see (R1)
        end
        asr_pkg::ADDR_CONVERSION_STATUS: begin
          prdata_nxt[asr_pkg::FLAG_WIDTH-1:0] = statusWord; // see (R13)
        end
        asr_pkg::ADDR_LAST_RESULT: begin
          prdata_nxt[asr_pkg::RESULT_WIDTH-1:0] = lastResultValue_r; // see (R8) (R13)
        end
        asr_pkg::ADDR_IRQ_MASK_VIEW: begin
          prdata_nxt[asr_pkg::FLAG_WIDTH-1:0] = irqEnable_r; // see (R11)
        end
        asr_pkg::ADDR_RX_TRANSFER_COUNTER: begin
          prdata_nxt[asr_pkg::COUNT_WIDTH-1:0] = rxCount_r;
        end
        asr_pkg::ADDR_RX_NEXT_TRANSFER_COUNTER: begin
          prdata_nxt[asr_pkg::COUNT_WIDTH-1:0] = rxNextCount_r;
        end
        default: begin
          prdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge refClk or negedge resetn) begin
    if (!resetn) begin
      convDoneFlag_r <= 8'h00;
      channelOverrunFlag_r <= 8'h00;
      resultAvailableFlag_r <= 1'b0;
      globalOverrunFlag_r <= 1'b0;
      rxCountZeroFlag_r <= 1'b0;
      lastResultValue_r <= asr_pkg::RESET_RESULT;
      irqEnable_r <= asr_pkg::RESET_FLAGS;
      rxCount_r <= asr_pkg::RESET_COUNT;
      rxNextCount_r <= asr_pkg::RESET_COUNT;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      convDoneFlag_r <= convDoneFlag_nxt;
      channelOverrunFlag_r <= channelOverrunFlag_nxt;
      resultAvailableFlag_r <= resultAvailableFlag_nxt;
      globalOverrunFlag_r <= globalOverrunFlag_nxt;
      rxCountZeroFlag_r <= rxCountZeroFlag_nxt;
      lastResultValue_r <= lastResultValue_nxt;
      irqEnable_r <= irqEnable_nxt;
      rxCount_r <= rxCount_nxt;
      rxNextCount_r <= rxNextCount_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= pready_nxt;
    end
  end

  assign rxTransferCounter = rxCount_r;
  assign rxNextTransferCounter = rxNextCount_r;

endmodule

// file: common/asr_pkg.sv
package asr_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CHANNEL_STATE = 8'h00;
  localparam logic [7:0] ADDR_CONVERSION_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LAST_RESULT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE_SET = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK_VIEW = 8'h14;
  localparam logic [7:0] ADDR_RX_TRANSFER_COUNTER = 8'h18;
  localparam logic [7:0] ADDR_RX_NEXT_TRANSFER_COUNTER = 8'h1C;

  // ==========================================================
  // Field layout
  localparam int NUM_CHANNELS = 8;
  localparam int RESULT_WIDTH = 10;
  localparam int COUNT_WIDTH = 16;
  localparam int FLAG_WIDTH = 20;
  localparam int POS_CONV_DONE = 0;
  localparam int POS_CHANNEL_OVERRUN = 8;
  localparam int POS_RESULT_AVAILABLE = 16;
  localparam int POS_GLOBAL_OVERRUN = 17;
  localparam int POS_RX_COUNT_ZERO = 18;
  localparam int POS_RX_BOTH_COUNTS_ZERO = 19;

  // ==========================================================
  // Reset values
  localparam logic [FLAG_WIDTH-1:0] RESET_FLAGS = 20'h00000;
  localparam logic [RESULT_WIDTH-1:0] RESET_RESULT = 10'h000;
  localparam logic [COUNT_WIDTH-1:0] RESET_COUNT = 16'h0000;

  // ==========================================================
  // Converter core events in one cycle
  typedef struct packed {
    logic convDone;
    logic [2:0] convChannel;
    logic [RESULT_WIDTH-1:0] convResult;
    logic [NUM_CHANNELS-1:0] channelOverrun;
    logic globalOverrun;
    logic rxTransferDone;
  } asr_core_evt_t;

endpackage

// file: verif/asr_status_regs_asserts.sv
// ==========
// Port checker
module asr_status_regs_asserts (
  input wire logic refClk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [asr_pkg::NUM_CHANNELS-1:0] channelOnBits,
  input wire asr_pkg::asr_core_evt_t coreEvt,
  input wire logic [asr_pkg::NUM_CHANNELS-1:0] channelDataRead,
  input wire logic [asr_pkg::NUM_CHANNELS-1:0] channelDataLoad,
  input wire logic [asr_pkg::COUNT_WIDTH-1:0] rxTransferCounter,
  input wire logic [asr_pkg::COUNT_WIDTH-1:0] rxNextTransferCounter,
  input wire logic irqOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge refClk);
  endclocking
  default disable iff (!resetn);
  sequence rd(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  AST_LOAD: assert property (channelDataLoad == (coreEvt.convDone ?
    channelOnBits & (8'h01 << coreEvt.convChannel) : 8'h00)) else $error("bad data load");
  AST_CHST: assert property (rd(asr_pkg::ADDR_CHANNEL_STATE) |->
    prdata == {24'h000000, $past(channelOnBits)}) else $error("channel state wrong");
  AST_STHI: assert property (rd(asr_pkg::ADDR_CONVERSION_STATUS) |->
    prdata[31:20] == 12'h000) else $error("status upper bits set");
  AST_LRHI: assert property (rd(asr_pkg::ADDR_LAST_RESULT) |->
    prdata[31:10] == 22'h000000) else $error("result upper bits set");
  AST_BOTH: assert property (rd(asr_pkg::ADDR_CONVERSION_STATUS) |-> prdata[19] ==
    ($past(rxTransferCounter) == 16'h0000 && $past(rxNextTransferCounter) == 16'h0000))
    else $error("both-zero flag wrong");
  AST_RESULT_AVAILABLE_FLAG: assert property (rd(asr_pkg::ADDR_LAST_RESULT) ##0 !$past(coreEvt.convDone)
    ##0 !coreEvt.convDone ##1 !coreEvt.convDone ##1 !coreEvt.convDone
    ##2 rd(asr_pkg::ADDR_CONVERSION_STATUS) |-> !prdata[16]) else $error("ready not cleared");
  AST_OVR: assert property (rd(asr_pkg::ADDR_CONVERSION_STATUS)
    ##0 $past(coreEvt.channelOverrun) == 8'h00 && !$past(coreEvt.globalOverrun)
    ##0 coreEvt.channelOverrun == 8'h00 && !coreEvt.globalOverrun
    ##1 coreEvt.channelOverrun == 8'h00 && !coreEvt.globalOverrun
    ##1 coreEvt.channelOverrun == 8'h00 && !coreEvt.globalOverrun
    ##2 rd(asr_pkg::ADDR_CONVERSION_STATUS)
    |-> prdata[15:8] == 8'h00 && !prdata[17]) else $error("overrun not cleared");
  AST_MASK: assert property (wr(asr_pkg::ADDR_IRQ_ENABLE_CLEAR) ##0 pwdata == 32'hFFFFFFFF
    ##4 wr(asr_pkg::ADDR_IRQ_ENABLE_SET) ##4 rd(asr_pkg::ADDR_IRQ_MASK_VIEW)
    |-> prdata == ($past(pwdata, 4) & 32'h000FFFFF)) else $error("mask view wrong");
  AST_IRQ: assert property (wr(asr_pkg::ADDR_IRQ_ENABLE_CLEAR) ##0 pwdata == 32'hFFFFFFFF
    |=> !irqOut) else $error("interrupt with all sources off");
endmodule

bind asr_status_regs asr_status_regs_asserts u_chk (.*);

// file: verif/asr_core_model.sv
// ==========
// Converter core and transfer counter events
module asr_core_model (
  input wire logic refClk,
  output logic [7:0] channelOnBits,
  output asr_pkg::asr_core_evt_t coreEvt,
  output logic [7:0] channelDataRead
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    channelOnBits = 8'h00;
    coreEvt = '0;
    channelDataRead = 8'h00;
  end
  task automatic setOn(input logic [7:0] b);
    @(posedge refClk);
    channelOnBits <= b;
  endtask
  task automatic fire(input asr_pkg::asr_core_evt_t e, input logic [7:0] r);
    asr_pkg::asr_core_evt_t idle;
    idle = '0;
    // Stale result is inverted so an unqualified capture shows up
    idle.convResult = ~e.convResult;
    @(posedge refClk);
    coreEvt <= e;
    channelDataRead <= r;
    @(posedge refClk);
    coreEvt <= idle;
    channelDataRead <= 8'h00;
  endtask
endmodule

// file: verif/asr_status_regs_tb.sv
// ==========
// Bench
module asr_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] aSt = asr_pkg::ADDR_CONVERSION_STATUS;
  logic refClk, resetn, psel, penable, pwrite, pready, pslverr, irqOut, errv;
  logic [7:0] paddr, channelOnBits, channelDataRead, channelDataLoad;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] rxTransferCounter, rxNextTransferCounter;
  asr_pkg::asr_core_evt_t coreEvt, ev;
  int nMismatch = 0;
  int checkCount = 0;
  asr_status_regs u_dut (.*);
  asr_core_model u_core (.*);
  initial begin
    refClk = 1'b0;
    forever #50 refClk = ~refClk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read data and pslverr are taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge refClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge refClk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge refClk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      nMismatch++;
      report_and_stop();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits one edge so that a write's effect on the interrupt level has settled
  task automatic chkIrq(input logic exp);
    @(posedge refClk);
    chk({31'h00000000, irqOut}, {31'h00000000, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdv, exp);
  endtask
  task automatic conv(input logic [2:0] ch, input logic [9:0] v);
    ev = '0;
    ev.convDone = 1'b1;
    ev.convChannel = ch;
    ev.convResult = v;
    u_core.fire(ev, 8'h00);
  endtask
  task automatic s_conv;
    rd(aSt, 32'h00080000);
    rd(asr_pkg::ADDR_IRQ_MASK_VIEW, 32'h00000000);
    u_core.setOn(8'hA5);
    rd(asr_pkg::ADDR_CHANNEL_STATE, 32'h000000A5);
    conv(3'h0, 10'h3FF);
    rd(aSt, 32'h00090001);
    rd(asr_pkg::ADDR_LAST_RESULT, 32'h000003FF);
    rd(aSt, 32'h00080001);
    conv(3'h1, 10'h155);
    rd(asr_pkg::ADDR_LAST_RESULT, 32'h00000155);
    rd(aSt, 32'h00080001);
    u_core.fire('0, 8'h01);
    rd(aSt, 32'h00080000);
  endtask
  task automatic s_ovr_rx;
    ev = '0;
    ev.channelOverrun = 8'h81;
    ev.globalOverrun = 1'b1;
    u_core.fire(ev, 8'h00);
    rd(aSt, 32'h000A8100);
    rd(aSt, 32'h00080000);
    apb(1'b1, asr_pkg::ADDR_RX_TRANSFER_COUNTER, 32'h00000002);
    apb(1'b1, asr_pkg::ADDR_RX_NEXT_TRANSFER_COUNTER, 32'h00000001);
    rd(aSt, 32'h00000000);
    ev = '0;
    ev.rxTransferDone = 1'b1;
    repeat (2) u_core.fire(ev, 8'h00);
    @(posedge refClk);
    chk({rxTransferCounter, rxNextTransferCounter}, 32'h00010000);
    rd(aSt, 32'h00040000);
    apb(1'b1, asr_pkg::ADDR_RX_NEXT_TRANSFER_COUNTER, 32'h00000000);
    rd(aSt, 32'h00000000);
    u_core.fire(ev, 8'h00);
    rd(aSt, 32'h000C0000);
  endtask
  task automatic s_irq;
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_SET, 32'h000A5A5A);
    rd(asr_pkg::ADDR_IRQ_MASK_VIEW, 32'h000A5A5A);
    chkIrq(1'b1);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_SET, 32'h00000000);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h00000000);
    rd(asr_pkg::ADDR_IRQ_MASK_VIEW, 32'h000A5A5A);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h00080000);
    chkIrq(1'b0);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_SET, 32'hFFFFFFFF);
    rd(asr_pkg::ADDR_IRQ_MASK_VIEW, 32'h000FFFFF);
    apb(1'b1, asr_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF);
    chkIrq(1'b0);
    apb(1'b0, 8'h20, 32'h00000000);
    chk({31'h00000000, errv}, 32'h00000001);
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (5) @(posedge refClk);
    resetn <= 1'b1;
    s_conv();
    s_ovr_rx();
    s_irq();
    report_and_stop();
  end
endmodule
